// ### piso_map.vh
// constants for the eight-stage parallel-in serial-out shifter
`ifndef PISO_MAP_VH
`define PISO_MAP_VH
`define PISO_STAGES 8
`define PISO_LAST 7
`define PISO_SEVENTH 6
`define PISO_SYNC_RST 2'h0
`define PISO_STAGE_RST 8'h00
`define PISO_HIST_RST 1'b1
`endif

// ### pin_sync.v
// two-flop synchroniser for one external pin
`include "piso_map.vh"

module pin_sync (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // pin in, synchronised level out
  input wire pin_i,
  output wire level_o
);
  reg [1:0] sync_r;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_r <= `PISO_SYNC_RST;
    end else begin
      sync_r <= {sync_r[0], pin_i};
    end
  end

  assign level_o = sync_r[1];
endmodule

// ### piso_shifter.v
// eight-stage parallel-in serial-out shifter, sampled on the system clock
`include "piso_map.vh"

module piso_shifter (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // control pins
  input wire shift_nload_i,
  input wire clock_in_i,
  input wire clock_gate_input_i,
  input wire serial_in_i,
  // parallel data pins
  input wire [`PISO_STAGES-1:0] parallel_inputs_i,
  // serial outputs
  output wire last_stage_out_o,
  output wire last_stage_out_n_o,
  // internal stage view
  output wire first_stage_bit_o,
  output wire seventh_stage_bit_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire shift_s;
  wire clk_s;
  wire gate_s;
  wire ser_s;
  wire [`PISO_STAGES-1:0] par_s;

  wire nor_clk;
  wire eff_clk;
  wire clk_rise;
  wire shift_mode;
  wire load_mode;

  wire first_bit;
  wire seventh_bit;
  wire last_bit;

  reg eff_clk_d_r;
  reg [`PISO_STAGES-1:0] stage_r;
  reg [`PISO_STAGES-1:0] stage_nxt;

  integer idx;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // two-input nor
  function nor2;
    input a;
    input b;
    begin
      nor2 = ~(a | b);
    end
  endfunction

  function rise;
    input now;
    input prev;
    begin
      rise = now & ~prev;
    end
  endfunction

  function [`PISO_STAGES-1:0] shift_word;
    input [`PISO_STAGES-1:0] word;
    input bit_in;
    begin
      shift_word = {word[`PISO_STAGES-2:0], bit_in};
    end
  endfunction

  // stage picked by index
  function stage_at;
    input [`PISO_STAGES-1:0] word;
    input integer pos;
    begin
      stage_at = word[pos];
    end
  endfunction

  // ----------------------------------------
  // control pin synchronisers
  // ----------------------------------------
  pin_sync u_sync_shift (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(shift_nload_i),
    .level_o(shift_s)
  );

  pin_sync u_sync_clk (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(clock_in_i),
    .level_o(clk_s)
  );

  pin_sync u_sync_gate (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(clock_gate_input_i),
    .level_o(gate_s)
  );

  pin_sync u_sync_ser (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(serial_in_i),
    .level_o(ser_s)
  );

  // ----------------------------------------
  // parallel pin synchronisers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PISO_STAGES; gi = gi + 1) begin : g_par
      pin_sync u_sync_par (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .pin_i(parallel_inputs_i[gi]),
        .level_o(par_s[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // shift mode when high
  assign shift_mode = shift_s;
  assign load_mode = ~shift_mode;

  // ----------------------------------------
  // effective clock
  // ----------------------------------------
  // nor of both clocks
  assign nor_clk = nor2(clk_s, gate_s);
  assign eff_clk = ~nor_clk;
  assign clk_rise = rise(eff_clk, eff_clk_d_r);

  // ----------------------------------------
  // clock history
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eff_clk_d_r <= `PISO_HIST_RST;
    end else begin
      eff_clk_d_r <= eff_clk;
    end
  end

  // ----------------------------------------
  // stage update
  // ----------------------------------------
  always @* begin
    stage_nxt = stage_r;
    idx = 0;

    if (load_mode) begin
      for (idx = 0; idx < `PISO_STAGES; idx = idx + 1) begin
        stage_nxt[idx] = par_s[idx];
      end
    end else if (shift_mode & clk_rise) begin
      stage_nxt = shift_word(stage_r, ser_s);
    end else begin
      stage_nxt = stage_r;
    end
  end

  // ----------------------------------------
  // stage registers
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_r <= `PISO_STAGE_RST;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // last stage is the eighth, bit 7
  assign last_bit = stage_at(stage_r, `PISO_LAST);
  assign seventh_bit = stage_at(stage_r, `PISO_SEVENTH);
  assign first_bit = stage_at(stage_r, 0);

  assign last_stage_out_o = last_bit;
  assign last_stage_out_n_o = ~last_bit;
  assign first_stage_bit_o = first_bit;
  assign seventh_stage_bit_o = seventh_bit;

endmodule

// ### piso_chk.sv
// port assertions for the shifter
module piso_chk (
  input wire ref_clk_i, rstn_i, shift_nload_i, clock_in_i, clock_gate_input_i, serial_in_i,
  input wire last_stage_out_o, last_stage_out_n_o, first_stage_bit_o, seventh_stage_bit_o,
  input wire [7:0] parallel_inputs_i
);
  logic [3:0] ck_r, nl_r;
  wire sh = nl_r[2] & !ck_r[2] & ck_r[3];
  always @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i) {ck_r, nl_r} <= 8'h0f;
    else {ck_r, nl_r} <= {ck_r[2:0], !(clock_in_i | clock_gate_input_i), nl_r[2:0], shift_nload_i};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_INV: assert property (last_stage_out_n_o != last_stage_out_o) else $error("inv");
  AST_LOAD: assert property (!nl_r[2] |-> last_stage_out_o == $past(parallel_inputs_i[7], 3))
    else $error("load");
  AST_FIRST: assert property (!nl_r[2] |-> first_stage_bit_o == $past(parallel_inputs_i[0], 3))
    else $error("first");
  AST_SHIFT: assert property (sh |-> first_stage_bit_o == $past(serial_in_i, 3))
    else $error("shift");
  AST_OUT: assert property (sh |-> last_stage_out_o == $past(seventh_stage_bit_o))
    else $error("out");
  AST_HOLD: assert property (nl_r[2] && !sh |-> $stable(last_stage_out_o)) else $error("hold");
endmodule
bind piso_shifter piso_chk chk (.*);

// ### piso_host.sv
// host model driving the shifter pins
module piso_host (input wire clk_i, output logic nl_o, ck_o, inh_o, si_o,
  output logic [7:0] par_o);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin nl_o = 0; ck_o = 1; inh_o = 0; si_o = 0; par_o = 8'h00; end
  task automatic step(input int n); repeat (n) @(negedge clk_i); endtask
  task automatic pulse(input logic c);
    if (c) ck_o = 1; else inh_o = 1;
    step(4);
    if (c) ck_o = 0; else inh_o = 0;
    step(4);
  endtask
  task automatic gate(input logic v);
    ck_o = 1; step(2); inh_o = v; step(2);
  endtask
endmodule

// ### piso_shifter_test.sv
// self-checking bench for the shifter
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, x, g); end end
module piso_shifter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rstn_i = 0, nl, ck, inh, si, q, qn, q0, q6;
  logic [7:0] par, e;
  int failures = 0, compares = 0, cyc = 0;
  piso_host host (.clk_i(ref_clk_i), .nl_o(nl), .ck_o(ck), .inh_o(inh), .si_o(si), .par_o(par));
  piso_shifter dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .shift_nload_i(nl), .clock_in_i(ck),
    .clock_gate_input_i(inh), .serial_in_i(si), .parallel_inputs_i(par), .last_stage_out_o(q),
    .last_stage_out_n_o(qn), .first_stage_bit_o(q0), .seventh_stage_bit_o(q6));
  initial begin forever #2 ref_clk_i = ~ref_clk_i; end
  always @(posedge ref_clk_i) begin cyc++; if (cyc == 2000) begin failures++; stop_test(); end end
  task automatic see(input logic [7:0] x);
    host.step(4); `CHK("out", x[7], q) `CHK("out_n", !x[7], qn)
    `CHK("first", x[0], q0) `CHK("seventh", x[6], q6)
  endtask
  task automatic t_load();
    host.par_o = 8'ha5; see(8'ha5);
    host.par_o = 8'h3c; see(8'h3c);
    host.pulse(1); see(8'h3c);
  endtask
  task automatic t_shift();
    e = 8'h3c; host.nl_o = 1;
    for (int i = 0; i < 8; i++) begin
      host.si_o = i[0]; host.pulse(i[1]); e = {e[6:0], i[0]}; see(e);
    end
  endtask
  task automatic t_hold();
    host.gate(1); e = {e[6:0], host.si_o}; see(e);
    host.si_o = !e[0]; host.pulse(1); host.gate(0); see(e);
  endtask
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rstn_i = 1;
    host.step(2); t_load(); t_shift(); t_hold(); stop_test();
  end
endmodule
